// ### design/spi_sel_pkg.sv
// Function
// - master, select output: auto bit picks manual bit or transfer timing; ignored in slave.
// - master, output, manual: manual bit 0 drives inactive level, 1 drives active.
// - slave, select pin ignored: manual bit 1 means selected, 0 not selected.
// - select polarity bit 0 means active low, 1 means active high.
// - master: direction 0 makes select an input for violation detection; 1 output.
// - slave: direction 0 ignores select pin; direction 1 makes it a valid input.
// - master inserts wait count times one clock period between transfers.
// - wait count applies only in master mode, no effect in slave mode.
// - busy sets at transfer start, clears at completion; reads 0 in slave mode.
// - violation flag sets when outside drives select active while in master mode.
// - violation with interrupt enable forces slave, disables outputs, then flag clears.
// - tx empty sets at reset and on shifter load; transmit write clears it.
// - overflow sets when receive loads while full still set; receive read clears.
// - receive full sets on receive load, clears when software reads receive data.
// - clearing the interface enable clears every status bit.
// - violation interrupt enable works only in master mode with detection configured.
// - separate enables gate tx empty, overflow and receive full interrupts.
// - soft request bit sets the interrupt request; no effect while gate is 0.
// - master interrupt gate allows the request when 1, blocks it when 0.
// - mode bit in the first control register: 0 slave, 1 master.
package spi_sel_pkg;
	localparam logic [7:0] OFS_RX_DATA = 8'h00;
	localparam logic [7:0] OFS_TX_DATA = 8'h04;
	localparam logic [7:0] OFS_CTRL1 = 8'h08;
	localparam logic [7:0] OFS_SELECT = 8'h0C;
	localparam logic [7:0] OFS_WAIT = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_INT_CTRL = 8'h18;
	// control register 1 fields
	localparam int CTRL_ON_BIT = 0;
	localparam int CTRL_MODE_BIT = 1;
	// select pin control fields
	localparam int SEL_DIR_BIT = 8;
	localparam int SEL_POL_BIT = 9;
	localparam int SEL_MAN_BIT = 10;
	localparam int SEL_AUTO_BIT = 11;
	// status fields
	localparam int ST_RXFULL_BIT = 2;
	localparam int ST_OVF_BIT = 3;
	localparam int ST_TXEMPTY_BIT = 4;
	localparam int ST_VIOL_BIT = 5;
	localparam int ST_BUSY_BIT = 6;
	// interrupt control fields
	localparam int IC_GATE_BIT = 0;
	localparam int IC_SOFT_BIT = 1;
	localparam int IC_RXFULL_BIT = 2;
	localparam int IC_OVF_BIT = 3;
	localparam int IC_TXEMPTY_BIT = 4;
	localparam int IC_VIOL_BIT = 5;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0010;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [15:0] WAIT_ZERO = 16'h0000;
	localparam logic [15:0] WAIT_ONE = 16'h0001;

	typedef struct packed {
		logic auto_ctrl;
		logic manual;
		logic polarity;
		logic direction;
	} select_cfg_t;

	typedef struct packed {
		logic violation_int_en;
		logic tx_empty_int_en;
		logic rx_overflow_int_en;
		logic rx_full_int_en;
		logic soft_int_request;
		logic int_request_gate;
	} int_cfg_t;

	typedef struct packed {
		logic transfer_busy_flag;
		logic mode_violation_flag;
		logic tx_empty_flag;
		logic rx_overflow_flag;
		logic rx_full_flag;
	} status_t;

	typedef enum logic [1:0] {
		GAP_IDLE = 2'b00,
		GAP_WAIT = 2'b01
	} gap_state_t;
endpackage : spi_sel_pkg

// ### design/spi_select_wait_status_irq.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
module spi_select_wait_status_irq (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ss_in,
	output logic ss_out,
	output logic ss_oe,
	input wire logic sclk_tick,
	input wire logic xfer_start,
	input wire logic xfer_done,
	input wire logic rx_load,
	input wire logic [31:0] rx_word,
	output logic [31:0] tx_word,
	output logic start_allow,
	output logic master_mode,
	output logic interface_on,
	output logic slave_selected,
	output logic outputs_off,
	output logic irq
);
	import spi_sel_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// register state
	logic on_reg, on_next;
	logic mode_reg, mode_next;
	select_cfg_t sel_reg, sel_next;
	logic [15:0] wait_reg, wait_next;
	int_cfg_t ic_reg, ic_next;
	status_t st_reg, st_next;
	logic [31:0] tx_reg, tx_next;
	logic [31:0] rx_reg, rx_next;
	logic off_reg, off_next;
	logic ss_out_reg, ss_out_next;
	logic ss_oe_reg, ss_oe_next;
	logic sel_reg_out, sel_out_next;
	logic irq_reg, irq_next;
	gap_state_t gap_reg, gap_next;
	logic [15:0] gap_cnt_reg, gap_cnt_next;
	logic ss_meta_reg, ss_sync_reg;

	// bus channel state
	logic aw_held_reg, aw_held_next;
	logic [7:0] aw_addr_reg, aw_addr_next;
	logic w_held_reg, w_held_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;

	logic wr_fire, rd_fire, wr_hit, rd_hit;
	logic [31:0] wr_val, rd_val, old_val;
	logic tx_wr, rx_rd, ss_active_in, violation, detect_mode;

	////////////////////////////////////////////////////////////////////////
	// select pin input synchroniser, first stage read only by the second
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			// pulled-up pin idles high, so no false active level
			ss_meta_reg <= 1'b1;
			ss_sync_reg <= 1'b1;
		end else begin
			ss_meta_reg <= ss_in;
			ss_sync_reg <= ss_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus slave: address and data taken in either order, answer once both
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = !w_held_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign wr_fire = aw_held_reg && w_held_reg;
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	// decode and strobe merge of the pending write
	always_comb begin
		wr_hit = 1'b1;
		unique case (aw_addr_reg)
			OFS_TX_DATA: old_val = tx_reg;
			OFS_CTRL1: old_val = {30'h0, mode_reg, on_reg};
			OFS_SELECT: old_val = {20'h0, sel_reg, 8'h00};
			OFS_WAIT: old_val = {16'h0, wait_reg};
			OFS_INT_CTRL: old_val = {26'h0, ic_reg};
			default: begin
				old_val = 32'h0000_0000;
				wr_hit = 1'b0;
			end
		endcase
		for (int i = 0; i < 4; i++) begin
			wr_val[i*8 +: 8] = w_strb_reg[i] ? w_data_reg[i*8 +: 8]
				: old_val[i*8 +: 8];
		end
	end

	// read decode; status and receive data show the block's own state
	always_comb begin
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			OFS_RX_DATA: rd_val = rx_reg;
			OFS_TX_DATA: rd_val = tx_reg;
			OFS_CTRL1: rd_val = {30'h0, mode_reg, on_reg};
			OFS_SELECT: rd_val = {20'h0, sel_reg, 8'h00};
			OFS_WAIT: rd_val = {16'h0, wait_reg};
			OFS_STATUS: rd_val = {25'h0, st_reg, 2'h0};
			OFS_INT_CTRL: rd_val = {26'h0, ic_reg};
			default: begin
				rd_val = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// bus channel next state
	always_comb begin
		aw_held_next = aw_held_reg;
		aw_addr_next = aw_addr_reg;
		w_held_next = w_held_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_next = 1'b1;
			aw_addr_next = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (rd_fire) begin
			rvalid_next = 1'b1;
			rdata_next = rd_val;
			rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers, violation handling, status flags, pins
	assign tx_wr = wr_fire && (aw_addr_reg == OFS_TX_DATA);
	assign rx_rd = rd_fire && (s_axi_araddr == OFS_RX_DATA);
	// pin level compared against the programmed active level
	assign ss_active_in = (ss_sync_reg == sel_reg.polarity);
	assign detect_mode = mode_reg && !sel_reg.direction;
	assign violation = on_reg && detect_mode && ss_active_in;

	always_comb begin
		on_next = on_reg;
		mode_next = mode_reg;
		sel_next = sel_reg;
		wait_next = wait_reg;
		ic_next = ic_reg;
		tx_next = tx_reg;
		rx_next = rx_reg;
		st_next = st_reg;
		off_next = off_reg;
		if (wr_fire) begin
			unique case (aw_addr_reg)
				OFS_TX_DATA: tx_next = wr_val;
				OFS_CTRL1: begin
					on_next = wr_val[CTRL_ON_BIT];
					mode_next = wr_val[CTRL_MODE_BIT];
					// a fresh mode choice releases the outputs again
					off_next = 1'b0;
				end
				OFS_SELECT: begin
					sel_next.auto_ctrl = wr_val[SEL_AUTO_BIT];
					sel_next.manual = wr_val[SEL_MAN_BIT];
					sel_next.polarity = wr_val[SEL_POL_BIT];
					sel_next.direction = wr_val[SEL_DIR_BIT];
				end
				OFS_WAIT: wait_next = wr_val[15:0];
				OFS_INT_CTRL: ic_next = int_cfg_t'(wr_val[5:0]);
				default: ;
			endcase
		end
		// reads and writes clear first so a same-cycle event wins
		if (tx_wr) st_next.tx_empty_flag = 1'b0;
		if (rx_rd) begin
			st_next.rx_full_flag = 1'b0;
			st_next.rx_overflow_flag = 1'b0;
		end
		if (xfer_start) st_next.tx_empty_flag = 1'b1;
		if (rx_load) begin
			rx_next = rx_word;
			st_next.rx_full_flag = 1'b1;
			if (st_reg.rx_full_flag) st_next.rx_overflow_flag = 1'b1;
		end
		// busy tracks transfers only while master
		if (xfer_done) st_next.transfer_busy_flag = 1'b0;
		if (xfer_start && mode_reg) st_next.transfer_busy_flag = 1'b1;
		// error cancelled: drop to slave with outputs off, flag clears
		if (st_reg.mode_violation_flag && ic_reg.violation_int_en) begin
			mode_next = 1'b0;
			off_next = 1'b1;
			st_next.mode_violation_flag = 1'b0;
		end
		// after the cancel, so a forced slave drop also clears busy
		if (!mode_next) st_next.transfer_busy_flag = 1'b0;
		if (violation) st_next.mode_violation_flag = 1'b1;
		// dropping the enable wipes the status word; the reset value
		// with tx empty set stays readable until then
		if (on_reg && !on_next) st_next = status_t'(5'h00);
		// re-enabling restores the empty transmit buffer
		if (!on_reg && on_next) st_next.tx_empty_flag = 1'b1;
	end

	// select pin drive and slave selection
	always_comb begin
		ss_oe_next = 1'b0;
		ss_out_next = !sel_reg.polarity;
		sel_out_next = 1'b0;
		if (mode_reg) begin
			ss_oe_next = sel_reg.direction && !off_reg;
			if (sel_reg.auto_ctrl) begin
				// active for the whole transfer in auto mode
				ss_out_next = st_reg.transfer_busy_flag ~^ sel_reg.polarity;
			end else begin
				ss_out_next = sel_reg.manual ~^ sel_reg.polarity;
			end
		end else if (sel_reg.direction) begin
			sel_out_next = ss_active_in;
		end else begin
			sel_out_next = sel_reg.manual;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// inter-transfer gap, counted in clock periods from the divider
	always_comb begin
		gap_next = gap_reg;
		gap_cnt_next = gap_cnt_reg;
		unique case (gap_reg)
			GAP_IDLE: begin
				if (xfer_done && mode_reg && wait_reg != WAIT_ZERO) begin
					gap_next = GAP_WAIT;
					gap_cnt_next = wait_reg;
				end
			end
			GAP_WAIT: begin
				if (!mode_reg) begin
					gap_next = GAP_IDLE;
				end else if (sclk_tick) begin
					gap_cnt_next = gap_cnt_reg - WAIT_ONE;
					if (gap_cnt_reg == WAIT_ONE) gap_next = GAP_IDLE;
				end
			end
		endcase
	end

	// interrupt request line
	always_comb begin
		irq_next = ic_reg.int_request_gate && (
			ic_reg.soft_int_request ||
			(st_reg.tx_empty_flag && ic_reg.tx_empty_int_en) ||
			(st_reg.rx_overflow_flag && ic_reg.rx_overflow_int_en) ||
			(st_reg.rx_full_flag && ic_reg.rx_full_int_en) ||
			(st_reg.mode_violation_flag && ic_reg.violation_int_en &&
				detect_mode));
	end

	////////////////////////////////////////////////////////////////////////
	// all state registers except the select pin synchroniser
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			on_reg <= 1'b0;
			mode_reg <= 1'b0;
			sel_reg <= select_cfg_t'(4'h0);
			wait_reg <= WAIT_ZERO;
			ic_reg <= int_cfg_t'(6'h00);
			st_reg <= status_t'(STATUS_RESET[6:2]);
			tx_reg <= 32'h0000_0000;
			rx_reg <= 32'h0000_0000;
			off_reg <= 1'b0;
			ss_out_reg <= 1'b1;
			ss_oe_reg <= 1'b0;
			sel_reg_out <= 1'b0;
			irq_reg <= 1'b0;
			gap_reg <= GAP_IDLE;
			gap_cnt_reg <= WAIT_ZERO;
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
		end else begin
			on_reg <= on_next;
			mode_reg <= mode_next;
			sel_reg <= sel_next;
			wait_reg <= wait_next;
			ic_reg <= ic_next;
			st_reg <= st_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
			off_reg <= off_next;
			ss_out_reg <= ss_out_next;
			ss_oe_reg <= ss_oe_next;
			sel_reg_out <= sel_out_next;
			irq_reg <= irq_next;
			gap_reg <= gap_next;
			gap_cnt_reg <= gap_cnt_next;
			aw_held_reg <= aw_held_next;
			aw_addr_reg <= aw_addr_next;
			w_held_reg <= w_held_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	// outputs to pins and to the shift engine
	assign ss_out = ss_out_reg;
	assign ss_oe = ss_oe_reg;
	assign slave_selected = sel_reg_out;
	assign irq = irq_reg;
	assign tx_word = tx_reg;
	assign master_mode = mode_reg;
	assign interface_on = on_reg;
	assign outputs_off = off_reg;
	// engine may start only with data ready and the gap elapsed
	assign start_allow = on_reg && mode_reg && !st_reg.tx_empty_flag &&
		!st_reg.transfer_busy_flag && (gap_reg == GAP_IDLE);

	////////////////////////////////////////////////////////////////////////
	// assertions
	property p_auto_sel;
		@(posedge sys_clk) disable iff (!rst_n)
		mode_reg && sel_reg.auto_ctrl && sel_reg.direction && !off_reg
		|=> ss_oe && (ss_out == ($past(st_reg.transfer_busy_flag)
			~^ $past(sel_reg.polarity)));
	endproperty
	a_auto_sel: assert property (p_auto_sel)
		else $error("auto select level wrong");

	property p_manual_sel;
		@(posedge sys_clk) disable iff (!rst_n)
		mode_reg && !sel_reg.auto_ctrl |=>
			ss_out == ($past(sel_reg.manual) ~^ $past(sel_reg.polarity));
	endproperty
	a_manual_sel: assert property (p_manual_sel)
		else $error("manual select level wrong");

	property p_slave_manual;
		@(posedge sys_clk) disable iff (!rst_n)
		!mode_reg && !sel_reg.direction |=>
			slave_selected == $past(sel_reg.manual);
	endproperty
	a_slave_manual: assert property (p_slave_manual)
		else $error("ignored pin slave selection wrong");

	property p_no_drive_input;
		@(posedge sys_clk) disable iff (!rst_n)
		!sel_reg.direction || !mode_reg |=> !ss_oe;
	endproperty
	a_no_drive_input: assert property (p_no_drive_input)
		else $error("select driven while input");

	property p_gap_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		xfer_done && mode_reg && wait_reg != WAIT_ZERO
		|=> !start_allow [*2];
	endproperty
	a_gap_hold: assert property (p_gap_hold)
		else $error("start allowed inside wait gap");

	property p_busy_slave;
		@(posedge sys_clk) disable iff (!rst_n)
		!mode_reg |-> !st_reg.transfer_busy_flag;
	endproperty
	a_busy_slave: assert property (p_busy_slave)
		else $error("busy set in slave mode");

	property p_violation_set;
		@(posedge sys_clk) disable iff (!rst_n)
		violation && on_next |=> st_reg.mode_violation_flag;
	endproperty
	a_violation_set: assert property (p_violation_set)
		else $error("violation not flagged");

	property p_cancel;
		@(posedge sys_clk) disable iff (!rst_n)
		st_reg.mode_violation_flag && ic_reg.violation_int_en && !wr_fire
		|=> !mode_reg && outputs_off ##1 !ss_oe;
	endproperty
	a_cancel: assert property (p_cancel)
		else $error("violation not cancelled");

	property p_txe_write;
		@(posedge sys_clk) disable iff (!rst_n)
		tx_wr && !xfer_start && on_reg && on_next
		|=> !st_reg.tx_empty_flag;
	endproperty
	a_txe_write: assert property (p_txe_write)
		else $error("tx empty not cleared by write");

	property p_overflow;
		@(posedge sys_clk) disable iff (!rst_n)
		rx_load && st_reg.rx_full_flag && on_next |=>
			st_reg.rx_overflow_flag && st_reg.rx_full_flag;
	endproperty
	a_overflow: assert property (p_overflow)
		else $error("overflow not flagged");

	property p_disabled_clear;
		@(posedge sys_clk) disable iff (!rst_n)
		on_reg && !on_next |=> st_reg == status_t'(5'h00);
	endproperty
	a_disabled_clear: assert property (p_disabled_clear)
		else $error("status not cleared while disabled");

	property p_irq_gate;
		@(posedge sys_clk) disable iff (!rst_n)
		!ic_reg.int_request_gate |=> !irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("irq raised with gate off");

	property p_soft_irq;
		@(posedge sys_clk) disable iff (!rst_n)
		ic_reg.int_request_gate && ic_reg.soft_int_request |=> irq;
	endproperty
	a_soft_irq: assert property (p_soft_irq)
		else $error("soft request not raised");
endmodule : spi_select_wait_status_irq

// ### verification/spi_far_end.sv
`timescale 1ns/100ps
module spi_far_end (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic start_allow,
	input wire logic [31:0] tx_word,
	input wire logic ss_out,
	input wire logic ss_oe,
	input wire logic ext_sel,
	input wire logic inject,
	output logic ss_in,
	output logic sclk_tick,
	output logic xfer_start,
	output logic xfer_done,
	output logic rx_load,
	output logic [31:0] rx_word,
	output int n_done,
	output int gap
);
	logic [4:0] div_reg;
	logic busy_reg;
	logic [31:0] shift_reg;
	int ticks;
	int idle_cnt;
	////////////////////////////////////////////////////////////////////////
	// select line: pull-up wins when nobody drives it
	assign ss_in = ss_oe ? ss_out : !ext_sel;
	// one tick per 160 ns link period
	assign sclk_tick = (div_reg == 5'h1F);
	////////////////////////////////////////////////////////////////////////
	// engine: four link periods a word; data comes back inverted
	// so a stale receive word never passes for a fresh one
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 5'h00;
			busy_reg <= 1'b0;
			shift_reg <= 32'h0000_0000;
			ticks <= 0;
			idle_cnt <= 0;
			n_done <= 0;
			gap <= 0;
			xfer_start <= 1'b0;
			xfer_done <= 1'b0;
			rx_load <= 1'b0;
			rx_word <= 32'h0000_0000;
		end else begin
			div_reg <= div_reg + 5'h01;
			xfer_start <= 1'b0;
			xfer_done <= 1'b0;
			rx_load <= inject;
			idle_cnt <= idle_cnt + 1;
			rx_word <= inject ? 32'h0000_C0DE : ~rx_word;
			if (!busy_reg && start_allow) begin
				xfer_start <= 1'b1;
				busy_reg <= 1'b1;
				shift_reg <= tx_word;
				ticks <= 0;
				gap <= idle_cnt; // cycles since the last word ended
			end else if (busy_reg && sclk_tick) begin
				ticks <= ticks + 1;
				if (ticks == 3) begin
					busy_reg <= 1'b0;
					xfer_done <= 1'b1;
					rx_load <= 1'b1;
					rx_word <= ~shift_reg;
					n_done <= n_done + 1;
					idle_cnt <= 0;
				end
			end
		end
	end
endmodule : spi_far_end

// ### verification/tb_spi_select_wait_status_irq.sv
`timescale 1ns/100ps
module tb_spi_select_wait_status_irq;
	import spi_sel_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1;
	logic s_axi_rready = 1'b1;
	logic ext_sel = 1'b0;
	logic inject = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, tx_word, rx_word, v;
	logic ss_in, ss_out, ss_oe, sclk_tick, xfer_start, xfer_done, rx_load;
	logic start_allow, master_mode, interface_on, slave_selected;
	logic outputs_off, irq;
	int error_cnt = 0;
	int n_compared = 0;
	int n_done, gap, i;
	// {interrupt control value, expected irq}
	logic [7:0] irq_tab [8] = '{8'h04, 8'h07, 8'h0B, 8'h02, 8'h13, 8'h23,
		8'h20, 8'h00};
	// {select bits 11:8, pin pulled low, expected selection}
	logic [11:0] sl_tab [5] = '{12'h401, 12'h002, 12'h103, 12'h302, 12'h100};

	always #2.5 sys_clk = ~sys_clk;

	spi_select_wait_status_irq u_dut (
		.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .ss_in, .ss_out, .ss_oe, .sclk_tick,
		.xfer_start, .xfer_done, .rx_load, .rx_word, .tx_word, .start_allow,
		.master_mode, .interface_on, .slave_selected, .outputs_off, .irq
	);

	spi_far_end u_far (
		.sys_clk, .rst_n, .start_allow, .tx_word, .ss_out, .ss_oe, .ext_sel,
		.inject, .ss_in, .sclk_tick, .xfer_start, .xfer_done, .rx_load,
		.rx_word, .n_done, .gap
	);
	////////////////////////////////////////////////////////////////////////
	// bus helpers: ready sampled before the edge's updates land
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk($sformatf("reg %h", a), e, v);
	endtask : rc

	task automatic end_sim();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst_n = 1'b0;
		cyc(5);
		rst_n <= 1'b1;
		cyc(1);
		rc(OFS_STATUS, STATUS_RESET);
		rc(OFS_SELECT, 32'h0000_0000);
		rc(OFS_WAIT, 32'h0000_0000);
		rc(OFS_INT_CTRL, 32'h0000_0000);
		chk("ss_oe", 1'b0, ss_oe);
		chk("irq", 1'b0, irq);
		// read-only and unmapped places refuse writes
		wr(OFS_STATUS, 32'hFFFF_FFFF);
		chk("bresp", RESP_SLVERR, r);
		wr(8'h1C, 32'hFFFF_FFFF);
		chk("bresp", RESP_SLVERR, r);
		rd(8'h1C);
		chk("rresp", RESP_SLVERR, r);
		rc(OFS_STATUS, STATUS_RESET);
		// master, select pin driven from the manual bit
		wr(OFS_CTRL1, 32'h0000_0003);
		cyc(2);
		chk("master_mode", 1'b1, master_mode);
		chk("interface_on", 1'b1, interface_on);
		for (i = 0; i < 4; i++) begin
			v = 32'h0000_0100 | (32'(i) << 9);
			wr(OFS_SELECT, v);
			cyc(3);
			chk("ss_out", !(i[0] ^ i[1]), ss_out);
			chk("ss_oe", 1'b1, ss_oe);
			rc(OFS_SELECT, v);
		end
		// auto control: idle stays inactive although manual asks active
		wr(OFS_SELECT, 32'h0000_0D00);
		cyc(3);
		chk("ss_out", 1'b1, ss_out);
		wr(OFS_WAIT, 32'h0000_0002);
		rc(OFS_WAIT, 32'h0000_0002);
		rc(OFS_STATUS, 32'h0000_0010);
		wr(OFS_TX_DATA, 32'h1234_5678);
		cyc(4);
		rc(OFS_STATUS, 32'h0000_0050);
		wr(OFS_TX_DATA, 32'h0F0F_A5A5);
		rc(OFS_STATUS, 32'h0000_0040);
		chk("tx_word", 32'h0F0F_A5A5, tx_word);
		chk("ss_out", 1'b0, ss_out);
		for (i = 0; i < 2000 && n_done < 2; i++) cyc(1);
		cyc(4);
		chk("gap", 1'b1, (gap > 32 && gap < 72));
		chk("ss_out", 1'b1, ss_out);
		rc(OFS_STATUS, 32'h0000_001C);
		rc(OFS_RX_DATA, 32'hF0F0_5A5A);
		rc(OFS_STATUS, 32'h0000_0010);
		// gating with receive full, overflow and transmit empty standing
		inject <= 1'b1;
		cyc(2);
		inject <= 1'b0;
		for (i = 0; i < 8; i++) begin
			wr(OFS_INT_CTRL, {26'h0, irq_tab[i][6:1]});
			cyc(3);
			chk("irq", irq_tab[i][0], irq);
		end
		rc(OFS_RX_DATA, 32'h0000_C0DE);
		// another master pulls the pin active: flag only, then cancel
		wr(OFS_SELECT, 32'h0000_0000);
		wr(OFS_INT_CTRL, 32'h0000_0001);
		ext_sel <= 1'b1;
		cyc(6);
		rc(OFS_STATUS, 32'h0000_0030);
		chk("master_mode", 1'b1, master_mode);
		chk("irq", 1'b0, irq);
		wr(OFS_INT_CTRL, 32'h0000_0021);
		cyc(4);
		chk("master_mode", 1'b0, master_mode);
		chk("outputs_off", 1'b1, outputs_off);
		rc(OFS_STATUS, 32'h0000_0010);
		ext_sel <= 1'b0;
		wr(OFS_CTRL1, 32'h0000_0000);
		rc(OFS_STATUS, 32'h0000_0000);
		chk("interface_on", 1'b0, interface_on);
		// slave: selection from manual bit or pin, by direction
		wr(OFS_CTRL1, 32'h0000_0001);
		for (i = 0; i < 5; i++) begin
			ext_sel <= sl_tab[i][1];
			wr(OFS_SELECT, {20'h0, sl_tab[i][11:8], 8'h00});
			cyc(4);
			chk("slave_selected", sl_tab[i][0], slave_selected);
			chk("ss_oe", 1'b0, ss_oe);
		end
		// slave never starts a word, so busy stays clear
		wr(OFS_TX_DATA, 32'h0000_00A5);
		cyc(8);
		rc(OFS_STATUS, 32'h0000_0000);
		end_sim();
	end

	// watchdog: the sequence needs well under 20k cycles
	initial begin
		#100000;
		error_cnt++;
		end_sim();
	end
endmodule : tb_spi_select_wait_status_irq
